/* hw/bsc_core.sv */
// bridge sensor correction core with apb register access
// Overview of operation
// - bridge target: intermediate times 1.25 plus term times intermediate squared
// - one second-order coefficient, applied to one configured target
// - correction uses temperature upper 12 bits; output reports upper 8
// - offset-tc target: delta times (term*delta+tco) added before gain
// - gain-tc target: gain*(1+delta*(term*delta+tcg)) times offset sum
// - temperature is gain times (raw plus offset), linear only
// - store is a shift register shifting eight bits per read byte
// - programming uses internal charge pump, about 6 ms, no high voltage
// - commands: raw reads, calibration, store dump, store writes
// - analog modes drive corrected bridge to 11-bit converter code
// - one stored bit picks regulator set point 5.0 V or 5.5 V
// - reference trim 0111 lowest through 1000 highest, inverted sign
// - 1 V trim also fine-adjusts the regulator set point
// - reset held until supply threshold, then oscillator starts
// - oscillator trim: 000 nominal, 001..011 lower, 111..100 higher
// - listen 6 ms after power-on, then normal operation
// - normal operation converts and presents corrected values
// - command mode entered only inside the window, then held
// - from command mode, raw-mode command enters raw mode
// - raw mode sends uncorrected values, left only by power removal
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`include "bsc_regs.svh"
`default_nettype none
module bsc_core
	import bsc_pkg::*;
#(
	parameter int WINDOW_CYC = `BSC_WINDOW_CYC,
	parameter int PROG_CYC   = `BSC_PROG_CYC
)(
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// conversion results from the front end
	input  wire logic [13:0] adc_bridge,
	input  wire logic [13:0] adc_temp,
	input  wire logic        adc_valid,
	// analog output stage and trims
	output logic      [10:0] dac_code,
	output logic             dac_ratiometric,
	output logic             analog_out_en,
	output logic             reg_setpoint_55,
	output logic signed [4:0] ref1v_trim_level,
	output logic signed [4:0] ref5v_trim_level,
	output logic signed [9:0] osc_trim_khz,
	output logic             pump_en,
	// digital output strobe
	output logic      [7:0]  tx_byte,
	output logic             tx_valid,
	output logic      [1:0]  mode_state
);
	bsc_mode_t          mode;
	logic [22:0]        win_cnt;
	logic [22:0]        prog_cnt;
	logic [13:0]        raw_br;
	logic [11:0]        raw_t;
	logic [15:0]        gain_b, gain_t;
	logic signed [15:0] off_b, tcg, tco, second_order_term, off_t;
	logic [11:0]        t_ref;
	logic [7:0]         cfg;
	logic [11:0]        trim;
	logic [13:0]        br_out;
	logic [7:0]         t_out;
	logic [8*`BSC_NV_BYTES-1:0] nv_shift;
	logic               conv_pend;
	logic [1:0]         tx_phase;
	logic               apb_acc;

	assign apb_acc = psel && penable;

	// saturate a wide signed value into 14 unsigned bits
	function automatic logic [13:0] sat14(input logic signed [47:0] v);
		if (v < 0)
			sat14 = 14'h0000;
		else if (v > 48'sh3fff)
			sat14 = 14'h3fff;
		else
			sat14 = v[13:0];
	endfunction

	// reversed-sign trim code: 0111 lowest, 1000 highest
	function automatic logic signed [4:0] trim_level(input logic [3:0] c);
		trim_level = -$signed({c[3], c});
	endfunction

	// correction datapath, coefficients in q2.14 / q1.15
	logic signed [15:0] dt;
	logic signed [47:0] dsq, off_sum, gain_f, zb, br_lin, br_full;
	logic signed [47:0] t_full;
	always_comb
	begin
		dt      = $signed({4'h0, raw_t}) - $signed({4'h0, t_ref});
		dsq     = (48'(second_order_term) * 48'(dt)) >>> 15;
		off_sum = 48'($signed({1'b0, raw_br})) + 48'(off_b);
		gain_f  = 48'sh4000;
		case (bsc_sot_t'(cfg[`BSC_CFG_SOT_LSB +: 2]))
			bsc_sot_tco:
			begin
				off_sum = off_sum + ((48'(dt) * (dsq + 48'(tco))) >>> 12);
				gain_f  = gain_f + ((48'(dt) * 48'(tcg)) >>> 12);
			end
			bsc_sot_tcg:
			begin
				off_sum = off_sum + ((48'(dt) * 48'(tco)) >>> 12);
				gain_f  = gain_f + ((48'(dt) * (dsq + 48'(tcg))) >>> 12);
			end
			default:
			begin
				off_sum = off_sum + ((48'(dt) * 48'(tco)) >>> 12);
				gain_f  = gain_f + ((48'(dt) * 48'(tcg)) >>> 12);
			end
		endcase
		zb      = (((gain_f * 48'($signed({1'b0, gain_b}))) >>> 14) * off_sum)
			>>> 14;
		br_lin  = zb;
		// bridge target: zb*(1.25 + sot*zb)
		br_full = zb + (zb >>> 2) + ((((48'(second_order_term) * zb) >>> 15) * zb) >>> 14);
		if (bsc_sot_t'(cfg[`BSC_CFG_SOT_LSB +: 2]) != bsc_sot_bridge)
			br_full = br_lin;
		t_full  = (48'($signed({1'b0, gain_t}))
			* (48'($signed({4'h0, raw_t})) + 48'(off_t))) >>> 14;
	end

	// power-on window and mode sequencing
	logic cmd_wr;
	assign cmd_wr = apb_acc && pwrite && paddr == `BSC_CMD_OFS;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode    <= bsc_st_window;
			win_cnt <= 23'h000000;
		end
		else
		begin
			case (mode)
				bsc_st_window:
				begin
					if (cmd_wr && pwdata[7:0] == `BSC_CMD_ENTER_CM)
						mode <= bsc_st_command;
					else if (win_cnt == 23'(WINDOW_CYC - 1))
						mode <= bsc_st_normal;
					else
						win_cnt <= win_cnt + 23'h000001;
				end
				bsc_st_command:
					if (cmd_wr && pwdata[7:0] == `BSC_CMD_ENTER_RM)
						mode <= bsc_st_raw;
				bsc_st_raw:
					mode <= bsc_st_raw;
				bsc_st_normal:
					mode <= bsc_st_normal;
				default:
					mode <= bsc_st_window;
			endcase
		end
	end

	// raw conversions and corrected results
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			raw_br    <= 14'h0000;
			raw_t     <= 12'h000;
			conv_pend <= 1'b0;
		end
		else
		begin
			conv_pend <= adc_valid;
			if (adc_valid)
			begin
				raw_br <= adc_bridge;
				raw_t  <= adc_temp[13:2];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			br_out          <= 14'h0000;
			t_out           <= 8'h00;
			dac_code        <= 11'h000;
			dac_ratiometric <= 1'b0;
			analog_out_en   <= 1'b0;
		end
		else
		begin
			if (conv_pend)
			begin
				br_out <= sat14(br_full);
				t_out  <= 8'(sat14(t_full) >> 6);
			end
			dac_ratiometric <= cfg[`BSC_CFG_RATIO];
			analog_out_en   <= cfg[`BSC_CFG_ANALOG] && mode == bsc_st_normal;
			if (cfg[`BSC_CFG_ANALOG])
				dac_code <= br_out[13:3];
		end
	end

	// digital byte stream: bridge hi, lo, then optional temperature
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_byte  <= 8'h00;
			tx_valid <= 1'b0;
			tx_phase <= 2'h0;
		end
		else
		begin
			tx_valid <= 1'b0;
			if (conv_pend && (mode == bsc_st_raw
				|| (mode == bsc_st_normal && !cfg[`BSC_CFG_ANALOG])))
				tx_phase <= 2'h1;
			else if (tx_phase != 2'h0)
			begin
				tx_valid <= 1'b1;
				case (tx_phase)
					2'h1:
					begin
						// raw mode sends uncorrected bridge
						tx_byte  <= mode == bsc_st_raw ? {2'b00, raw_br[13:8]}
							: {2'b00, br_out[13:8]};
						tx_phase <= 2'h2;
					end
					2'h2:
					begin
						tx_byte  <= mode == bsc_st_raw ? raw_br[7:0]
							: br_out[7:0];
						tx_phase <= (mode == bsc_st_raw
							|| cfg[`BSC_CFG_TEMPOUT]) ? 2'h3 : 2'h0;
					end
					default:
					begin
						tx_byte  <= mode == bsc_st_raw ? raw_t[11:4] : t_out;
						tx_phase <= 2'h0;
					end
				endcase
			end
		end
	end

	// coefficient store and programming pump
	logic nv_wr, nv_rd;
	assign nv_wr = apb_acc && pwrite && paddr == `BSC_NVDATA_OFS
		&& mode == bsc_st_command;
	assign nv_rd = apb_acc && !pwrite && paddr == `BSC_NVDATA_OFS;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			nv_shift <= '0;
			prog_cnt <= 23'h000000;
			pump_en  <= 1'b0;
		end
		else
		begin
			if (nv_wr || nv_rd)
				nv_shift <= {nv_shift[8*`BSC_NV_BYTES-9:0],
					nv_wr ? pwdata[7:0] : nv_shift[8*`BSC_NV_BYTES-1 -: 8]};
			if (nv_wr)
			begin
				pump_en  <= 1'b1;
				prog_cnt <= 23'(PROG_CYC - 1);
			end
			else if (prog_cnt != 23'h000000)
				prog_cnt <= prog_cnt - 23'h000001;
			else
				pump_en <= 1'b0;
		end
	end

	// software coefficient registers
	logic cal_wr;
	assign cal_wr = apb_acc && pwrite && mode == bsc_st_command;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			gain_b <= 16'h4000;
			off_b  <= 16'sh0000;
			tcg    <= 16'sh0000;
			tco    <= 16'sh0000;
			second_order_term    <= 16'sh0000;
			t_ref  <= 12'h000;
			gain_t <= 16'h4000;
			off_t  <= 16'sh0000;
			cfg    <= `BSC_CFG_RESET;
			trim   <= `BSC_TRIM_RESET;
		end
		else if (cal_wr)
		begin
			case (paddr)
				`BSC_GAINB_OFS: gain_b <= pwdata[15:0];
				`BSC_OFFB_OFS:  off_b  <= $signed(pwdata[15:0]);
				`BSC_TCG_OFS:   tcg    <= $signed(pwdata[15:0]);
				`BSC_TCO_OFS:   tco    <= $signed(pwdata[15:0]);
				`BSC_SOT_OFS:   second_order_term    <= $signed(pwdata[15:0]);
				`BSC_TREF_OFS:  t_ref  <= pwdata[11:0];
				`BSC_GAINT_OFS: gain_t <= pwdata[15:0];
				`BSC_OFFT_OFS:  off_t  <= $signed(pwdata[15:0]);
				`BSC_CFG_OFS:   cfg    <= pwdata[7:0];
				`BSC_TRIM_OFS:  trim   <= pwdata[11:0];
				default:        cfg    <= cfg;
			endcase
		end
	end

	// trim decode to the analog blocks
	logic signed [9:0] osc_map;
	always_comb
	begin
		case (trim[`BSC_TRIM_OSC_LSB +: 3])
			3'h1:    osc_map = -10'sd40;
			3'h2:    osc_map = -10'sd76;
			3'h3:    osc_map = -10'sd110;
			3'h7:    osc_map = 10'sd65;
			3'h6:    osc_map = 10'sd140;
			3'h5:    osc_map = 10'sd235;
			3'h4:    osc_map = 10'sd385;
			default: osc_map = 10'sd0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			reg_setpoint_55  <= 1'b0;
			ref1v_trim_level <= 5'sh00;
			ref5v_trim_level <= 5'sh00;
			osc_trim_khz     <= 10'sh000;
		end
		else
		begin
			reg_setpoint_55  <= cfg[`BSC_CFG_REG55];
			// the 1 V level also fine-tunes the regulator
			ref1v_trim_level <= trim_level(trim[`BSC_TRIM_R1V_LSB +: 4]);
			ref5v_trim_level <= trim_level(trim[`BSC_TRIM_R5V_LSB +: 4]);
			osc_trim_khz     <= osc_map;
		end
	end

	// apb read and answer: zero wait states
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata     <= 32'h00000000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			mode_state <= 2'h0;
		end
		else
		begin
			mode_state <= mode;
			pready     <= psel && !penable;
			pslverr    <= 1'b0;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					`BSC_STATUS_OFS: prdata <= {29'h0, pump_en, mode};
					`BSC_RAWBR_OFS:  prdata <= {18'h0, raw_br};
					`BSC_RAWT_OFS:   prdata <= {20'h0, raw_t};
					`BSC_CFG_OFS:    prdata <= {24'h0, cfg};
					`BSC_TRIM_OFS:   prdata <= {20'h0, trim};
					`BSC_BROUT_OFS:  prdata <= {18'h0, br_out};
					`BSC_TOUT_OFS:   prdata <= {24'h0, t_out};
					`BSC_NVDATA_OFS: prdata <= {24'h0,
						nv_shift[8*`BSC_NV_BYTES-1 -: 8]};
					default:         prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // bsc_core
`default_nettype wire

/* pkg/bsc_regs.svh */
// register map, field positions, reset values and timing counts
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH
`define BSC_CTRL_OFS      12'h000
`define BSC_STATUS_OFS    12'h004
`define BSC_RAWBR_OFS     12'h008
`define BSC_RAWT_OFS      12'h00c
`define BSC_GAINB_OFS     12'h010
`define BSC_OFFB_OFS      12'h014
`define BSC_TCG_OFS       12'h018
`define BSC_TCO_OFS       12'h01c
`define BSC_SOT_OFS       12'h020
`define BSC_TREF_OFS      12'h024
`define BSC_GAINT_OFS     12'h028
`define BSC_OFFT_OFS      12'h02c
`define BSC_CFG_OFS       12'h030
`define BSC_TRIM_OFS      12'h034
`define BSC_BROUT_OFS     12'h038
`define BSC_TOUT_OFS      12'h03c
`define BSC_NVDATA_OFS    12'h040
`define BSC_CMD_OFS       12'h044
// ctrl fields
`define BSC_CTRL_CONV     0
`define BSC_CTRL_NVLOAD   1
// cfg fields
`define BSC_CFG_SOT_LSB   0
`define BSC_CFG_ANALOG    2
`define BSC_CFG_RATIO     3
`define BSC_CFG_TEMPOUT   4
`define BSC_CFG_REG55     5
// trim fields
`define BSC_TRIM_R1V_LSB  0
`define BSC_TRIM_R5V_LSB  4
`define BSC_TRIM_OSC_LSB  8
`define BSC_TRIM_RESET    12'h000
`define BSC_CFG_RESET     8'h00
// commands
`define BSC_CMD_ENTER_CM  8'h72
`define BSC_CMD_ENTER_RM  8'h73
// timing
`define BSC_CLK_HZ        20000000
`define BSC_WINDOW_US     6000
`define BSC_PROG_US       6000
`define BSC_WINDOW_CYC    ((`BSC_WINDOW_US * (`BSC_CLK_HZ / 1000000)))
`define BSC_PROG_CYC      ((`BSC_PROG_US * (`BSC_CLK_HZ / 1000000)))
`define BSC_NV_BYTES      14
`endif

/* pkg/bsc_pkg.sv */
// types shared by the correction core
`default_nettype none
package bsc_pkg;
	typedef enum logic [1:0] {bsc_sot_bridge, bsc_sot_tco, bsc_sot_tcg,
		bsc_sot_none} bsc_sot_t;
	typedef enum logic [1:0] {bsc_st_window, bsc_st_normal, bsc_st_command,
		bsc_st_raw} bsc_mode_t;
endpackage
`default_nettype wire

/* testbench/bsc_core_sva.sv */
// assertion checker watching the correction core ports
`default_nettype none
module bsc_core_sva (
	// clock, reset and bus
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              pready,
	input wire logic              pslverr,
	// outputs under watch
	input wire logic              reg_setpoint_55,
	input wire logic signed [4:0] ref1v_trim_level,
	input wire logic              pump_en,
	input wire logic [7:0]        tx_byte,
	input wire logic              tx_valid,
	input wire logic [1:0]        mode_state
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_wr(a);
		psel && penable && pready && pwrite && paddr == a;
	endsequence
	sequence s_cm_wr(a);
		s_wr(a) ##0 mode_state == 2'h2;
	endsequence
	AST_PREADY_NEXT: assert property (s_setup |=> pready)
		else $error("no answer after setup");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("pready held too long");
	AST_NO_SLVERR: assert property (pready |-> !pslverr)
		else $error("error response seen");
	// mode_state trails the mode by one edge: window check one edge on
	AST_CM_ENTRY: assert property ((s_wr(12'h044) ##0
		pwdata[7:0] == 8'h72 ##1 mode_state == 2'h0)
		|=> mode_state == 2'h2)
		else $error("command mode not entered");
	AST_CM_HOLD: assert property (mode_state == 2'h2 |=>
		mode_state inside {2'h2, 2'h3})
		else $error("command mode left");
	AST_RAW_HOLD: assert property (mode_state == 2'h3 |=> mode_state == 2'h3)
		else $error("raw mode left");
	// stored field lands at the write edge, its output one edge later
	AST_SETPOINT: assert property (s_cm_wr(12'h030) |-> ##2
		reg_setpoint_55 == $past(pwdata[5], 2))
		else $error("set point bit wrong");
	AST_TRIM_SIGN: assert property (s_cm_wr(12'h034) |-> ##2
		ref1v_trim_level == -$signed({$past(pwdata[3], 2),
		$past(pwdata[3:0], 2)}))
		else $error("reference trim level wrong");
	AST_PUMP: assert property (s_cm_wr(12'h040) |=> pump_en [*8])
		else $error("pump not running");
	AST_TX_HI: assert property ($rose(tx_valid) |->
		tx_byte[7:6] == 2'b00 ##1 tx_valid)
		else $error("bridge high byte malformed");
endmodule // bsc_core_sva
bind bsc_core bsc_core_sva u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.reg_setpoint_55(reg_setpoint_55), .ref1v_trim_level(ref1v_trim_level),
	.pump_en(pump_en), .tx_byte(tx_byte), .tx_valid(tx_valid),
	.mode_state(mode_state));
`default_nettype wire

/* testbench/bsc_fe_model.sv */
// front-end model delivering raw bridge and temperature conversions
`default_nettype none
module bsc_fe_model (
	// clock
	input  wire logic        pclk,
	// conversion results
	output logic      [13:0] adc_bridge,
	output logic      [13:0] adc_temp,
	output logic             adc_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		adc_bridge = 14'h0;
		adc_temp = 14'h0;
		adc_valid = 1'b0;
	end
	// data goes stale two edges after the latch edge
	task automatic convert(input logic [13:0] b, input logic [13:0] t);
		@(posedge pclk);
		adc_bridge <= b;
		adc_temp <= t;
		adc_valid <= 1'b1;
		@(posedge pclk);
		adc_valid <= 1'b0;
		repeat (2) @(posedge pclk);
		adc_bridge <= ~b;
		adc_temp <= ~t;
	endtask
endmodule // bsc_fe_model
`default_nettype wire

/* testbench/bsc_core_tb_top.sv */
// self-checking testbench for the correction core
`default_nettype none
module bsc_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int WIN = 200;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [11:0]       paddr = 12'h0;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata, rd;
	logic              pready, pslverr, adc_valid, tx_valid, pump_en;
	logic [13:0]       adc_bridge, adc_temp;
	logic [10:0]       dac_code;
	logic              dac_ratiometric, analog_out_en, reg_setpoint_55;
	logic signed [4:0] ref1v_trim_level, ref5v_trim_level;
	logic signed [9:0] osc_trim_khz;
	logic [7:0]        tx_byte;
	logic [1:0]        mode_state;
	logic [4:0]        e;
	logic [7:0]        txq[$];
	logic signed [9:0] osc_tab[8] = '{10'sd0, -10'sd40, -10'sd76, -10'sd110,
		10'sd385, 10'sd235, 10'sd140, 10'sd65};
	// corrected bridge for 0x800 raw, delta 0x400, term 0.125, per target
	logic [11:0]       sot_tab[4] = '{12'ha20, 12'h820, 12'h804, 12'h800};
	int                err_count = 0;
	int                check_count = 0;
	always #25 pclk = ~pclk;
	bsc_fe_model fe (.pclk(pclk), .adc_bridge(adc_bridge),
		.adc_temp(adc_temp), .adc_valid(adc_valid));
	bsc_core #(.WINDOW_CYC(WIN), .PROG_CYC(50)) dut (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_bridge(adc_bridge), .adc_temp(adc_temp),
		.adc_valid(adc_valid), .dac_code(dac_code),
		.dac_ratiometric(dac_ratiometric), .analog_out_en(analog_out_en),
		.reg_setpoint_55(reg_setpoint_55), .ref1v_trim_level(ref1v_trim_level),
		.ref5v_trim_level(ref5v_trim_level), .osc_trim_khz(osc_trim_khz),
		.pump_en(pump_en), .tx_byte(tx_byte), .tx_valid(tx_valid),
		.mode_state(mode_state));
	always @(posedge pclk)
		if (tx_valid === 1'b1)
			txq.push_back(tx_byte);
	task automatic tally_and_finish;
		if (err_count == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one apb transfer, request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1)
		begin
			err_count++;
			tally_and_finish();
		end
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		// registered outputs follow a write one edge later
		@(posedge pclk);
		#1;
	endtask
	task automatic rd_chk(string what, logic [11:0] a, logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask
	task automatic reset_dut;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		#1;
	endtask
	// one conversion, then compare the digital stream bytes
	task automatic conv_tx(logic [13:0] b, logic [13:0] t, int cnt,
		logic [23:0] exp);
		txq.delete();
		fe.convert(b, t);
		repeat (8) @(posedge pclk);
		check("tx count", 32'(cnt), 32'(txq.size()));
		for (int k = 0; k < cnt; k++)
			check("tx byte", {24'h0, exp[23 - 8 * k -: 8]}, {24'h0, txq[k]});
	endtask
	initial
	begin
		reset_dut();
		check("mode", 32'h0, {30'h0, mode_state});
		apb(1'b1, 12'h030, 32'h20);
		rd_chk("cfg", 12'h030, 32'h0);
		apb(1'b1, 12'h044, 32'h72);
		check("mode", 32'h2, {30'h0, mode_state});
		rd_chk("status", 12'h004, 32'h2);
		rd_chk("unmapped", 12'h100, 32'h0);
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b1, 12'h034, {21'h0, i[2:0], i[3:0], i[3:0]});
			e = 5'(i < 8 ? -i : 16 - i);
			check("ref1v", {27'h0, e}, {27'h0, ref1v_trim_level});
			check("ref5v", {27'h0, e}, {27'h0, ref5v_trim_level});
			check("osc", {22'h0, osc_tab[i % 8]}, {22'h0, osc_trim_khz});
		end
		apb(1'b1, 12'h034, 32'h0);
		apb(1'b1, 12'h030, 32'h2c);
		check("outputs", 32'h6, {29'h0, reg_setpoint_55, dac_ratiometric,
			analog_out_en});
		fe.convert(14'h0800, 14'h1000);
		repeat (8) @(posedge pclk);
		rd_chk("brout", 12'h038, 32'h0a00);
		check("dac", 32'h140, {21'h0, dac_code});
		rd_chk("rawbr", 12'h008, 32'h0800);
		rd_chk("rawt", 12'h00c, 32'h0400);
		rd_chk("tout", 12'h03c, 32'h0010);
		fe.convert(14'h3800, 14'h1000);
		repeat (8) @(posedge pclk);
		rd_chk("brout", 12'h038, 32'h3fff);
		apb(1'b1, 12'h020, 32'h1000);
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b1, 12'h030, 32'(s));
			fe.convert(14'h0800, 14'h1000);
			repeat (2) @(posedge pclk);
			rd_chk("brsot", 12'h038, {20'h0, sot_tab[s]});
		end
		for (int j = 1; j <= 14; j++)
		begin
			apb(1'b1, 12'h040, 32'(j));
			check("pump", 32'h1, {31'h0, pump_en});
			for (int n = 0; n < 200 && pump_en === 1'b1; n++)
				@(posedge pclk);
			check("pump off", 32'h0, {31'h0, pump_en});
		end
		for (int j = 1; j <= 14; j++)
			rd_chk("store", 12'h040, 32'(j));
		apb(1'b1, 12'h044, 32'h73);
		check("mode", 32'h3, {30'h0, mode_state});
		conv_tx(14'h2abc, 14'h3a5c, 3, 24'h2abce9);
		apb(1'b1, 12'h044, 32'h72);
		check("mode", 32'h3, {30'h0, mode_state});
		reset_dut();
		repeat (WIN - 30) @(posedge pclk);
		check("mode", 32'h0, {30'h0, mode_state});
		repeat (40) @(posedge pclk);
		check("mode", 32'h1, {30'h0, mode_state});
		apb(1'b1, 12'h044, 32'h72);
		check("mode", 32'h1, {30'h0, mode_state});
		conv_tx(14'h0800, 14'h1000, 2, 24'h0a0000);
		tally_and_finish();
	end
	initial
	begin
		repeat (100000) @(posedge pclk);
		err_count++;
		tally_and_finish();
	end
endmodule // bsc_core_tb_top
`default_nettype wire
